// >>> drcp_debug_register_command_port.sv
// Operation
// - The three staging bytes form one 24-bit value with the upper byte most significant.
// - Destinations narrower than 24 bits take only the low bits of the staging value.
// - The upper, high and low staging bytes decode at 13h, 14h and 15h.
// - The command register sits at 16h right after the staging bytes for one sequential burst.
// - Writing the command register starts its operation at once with no further trigger.
// - A read command loads the selected register into the upper, high and low result bytes.
// - A write command takes the value for the CPU destination from the staging bytes.
// - Codes 00 to 07 read page/F/A, BC, DE, HL, IX, IY, SP and PC in that order.
// - Codes 80 to 87 write the same groups in the same order from the staging bytes.
// - Stack commands 06 and 86 select the long pointer in long mode and the short one otherwise.
// - A byte written to the memory port is stored at the address held by the program counter.
// - The memory address is the full PC in long mode and page plus PC low 16 bits otherwise.
// - The program counter advances by one after each memory port byte.
// - The debug address does not advance on memory port bytes so a burst streams to memory.
// - The memory write port decodes at 30h.
// - Staging registers are write-only and hold no defined reset value; memory port address and data reset to zero.
`timescale 1ns/1ps

// ------------------------------------------------------------------
// Byte FIFO between the debug link decoder and the command executor
// ------------------------------------------------------------------
module drcp_fifo #(
  parameter int unsigned WIDTH = 16,
  parameter int unsigned DEPTH = drcp_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             reset,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int unsigned PTR_W = $clog2(DEPTH);

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("drcp_fifo depth must be a power of two of at least two");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PTR_W-1:0] wr_ptr;
  logic [PTR_W-1:0] rd_ptr;
  logic [PTR_W:0]   count;
  logic [PTR_W:0]   next_count;
  wire              push = in_valid && in_ready;
  wire              pop  = out_valid && out_ready;

  assign out_data = mem[rd_ptr];

  always_comb begin
    next_count = count;
    if (push && !pop)
      next_count = count + 1'b1;
    else if (pop && !push)
      next_count = count - 1'b1;
  end

  // Full and empty come from flip-flops so the ready seen by the link is clean.
  always_ff @(posedge clk) begin
    if (reset) begin
      wr_ptr    <= '0;
      rd_ptr    <= '0;
      count     <= '0;
      in_ready  <= 1'b0;
      out_valid <= 1'b0;
    end else begin
      if (push)
        wr_ptr <= wr_ptr + 1'b1;
      if (pop)
        rd_ptr <= rd_ptr + 1'b1;
      count     <= next_count;
      in_ready  <= next_count != (PTR_W+1)'(DEPTH);
      out_valid <= next_count != '0;
    end
  end

  always_ff @(posedge clk) begin
    if (push)
      mem[wr_ptr] <= in_data;
  end

endmodule : drcp_fifo

// ------------------------------------------------------------------
// Debug register and command port
// ------------------------------------------------------------------
module drcp_debug_register_command_port #(
  parameter int unsigned FIFO_DEPTH = drcp_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // Debug link side, already framed by the link decoder
  input  wire logic        dbg_addr_load,
  input  wire logic [7:0]  dbg_addr,
  input  wire logic        dbg_data_valid,
  output logic             dbg_data_ready,
  input  wire logic [7:0]  dbg_data,
  // Read result bytes
  output logic [7:0]       read_result_upper,
  output logic [7:0]       read_result_high,
  output logic [7:0]       read_result_low,
  // CPU register file
  output logic             reg_read_req,
  output logic             reg_write_strobe,
  output logic [2:0]       reg_group,
  output logic             reg_sp_long,
  output logic [23:0]      reg_write_data,
  input  wire logic        reg_read_valid,
  input  wire logic [23:0] reg_read_data,
  // CPU state
  input  wire logic        long_address_mode,
  input  wire logic [7:0]  memory_base_page,
  input  wire logic [23:0] cpu_pc,
  output logic             pc_increment,
  // Memory write path
  output logic             mem_wr_req,
  output logic [23:0]      mem_wr_addr,
  output logic [7:0]       mem_wr_data,
  input  wire logic        mem_wr_ack
);

  // ----------------------------------------------------------------
  // Address tracking and buffering
  // ----------------------------------------------------------------
  localparam int unsigned ENTRY_W = drcp_pkg::ADDR_W + drcp_pkg::DATA_W;

  drcp_pkg::drcp_state_t state;
  logic [7:0]            cur_addr;
  logic                  fifo_ready;
  logic                  fifo_valid;
  logic [ENTRY_W-1:0]    fifo_entry;
  logic [7:0]            write_stage_upper;
  logic [7:0]            write_stage_high;
  logic [7:0]            write_stage_low;

  wire       link_push   = dbg_data_valid && fifo_ready;
  wire [7:0] link_addr   = dbg_addr_load ? dbg_addr : cur_addr;
  wire       at_mem_port = link_addr == drcp_pkg::ADDR_MEM_WR;

  // A byte offered together with an address load goes to the new address.
  always_ff @(posedge clk) begin
    if (reset)
      cur_addr <= '0;
    else if (link_push && !at_mem_port)
      cur_addr <= link_addr + drcp_pkg::ADDR_STEP;
    else if (dbg_addr_load)
      cur_addr <= dbg_addr;
  end

  // The address travels with each byte, so a later address load never retargets queued data.
  drcp_fifo #(
    .WIDTH (ENTRY_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .reset     (reset),
    .in_valid  (dbg_data_valid),
    .in_ready  (fifo_ready),
    .in_data   ({link_addr, dbg_data}),
    .out_valid (fifo_valid),
    .out_ready (state == drcp_pkg::ST_IDLE),
    .out_data  (fifo_entry)
  );

  // The link sees the buffer's own ready, so a full buffer holds the host off instead of
  // silently dropping a byte.
  assign dbg_data_ready = fifo_ready;

  // ----------------------------------------------------------------
  // Decode of the byte at the head of the buffer
  // ----------------------------------------------------------------
  wire [7:0]  q_addr    = fifo_entry[ENTRY_W-1:drcp_pkg::DATA_W];
  wire [7:0]  q_data    = fifo_entry[drcp_pkg::DATA_W-1:0];
  wire        take      = fifo_valid && state == drcp_pkg::ST_IDLE;
  wire        hit_upper = take && q_addr == drcp_pkg::ADDR_WR_UPPER;
  wire        hit_high  = take && q_addr == drcp_pkg::ADDR_WR_HIGH;
  wire        hit_low   = take && q_addr == drcp_pkg::ADDR_WR_LOW;
  wire        hit_cmd   = take && q_addr == drcp_pkg::ADDR_COMMAND;
  wire        hit_mem   = take && q_addr == drcp_pkg::ADDR_MEM_WR;
  wire [4:0]  cmd_tag   = q_data[drcp_pkg::CMD_TAG_MSB:drcp_pkg::CMD_TAG_LSB];
  wire [2:0]  cmd_group = q_data[drcp_pkg::CMD_GROUP_MSB:0];
  wire        cmd_read  = hit_cmd && cmd_tag == drcp_pkg::CMD_TAG_READ;
  wire        cmd_write = hit_cmd && cmd_tag == drcp_pkg::CMD_TAG_WRITE;
  wire [23:0] stage_val = {write_stage_upper, write_stage_high, write_stage_low};
  wire [23:0] mem_addr  = long_address_mode ? cpu_pc
                                            : {memory_base_page, cpu_pc[15:0]};

  // ----------------------------------------------------------------
  // Staging bytes
  // ----------------------------------------------------------------
  // No reset here: these bytes are write-only and start undefined.
  always_ff @(posedge clk) begin
    if (hit_upper)
      write_stage_upper <= q_data;
    if (hit_high)
      write_stage_high <= q_data;
    if (hit_low)
      write_stage_low <= q_data;
  end

  // ----------------------------------------------------------------
  // Command executor
  // ----------------------------------------------------------------
  // After any CPU update the executor waits one cycle so the next byte sees the new PC.
  always_ff @(posedge clk) begin
    if (reset) begin
      state <= drcp_pkg::ST_IDLE;
    end else begin
      unique case (state)
        drcp_pkg::ST_IDLE: begin
          if (cmd_read)
            state <= drcp_pkg::ST_READ_WAIT;
          else if (cmd_write)
            state <= drcp_pkg::ST_SETTLE;
          else if (hit_mem)
            state <= drcp_pkg::ST_MEM_WAIT;
        end
        drcp_pkg::ST_READ_WAIT: begin
          if (reg_read_valid)
            state <= drcp_pkg::ST_IDLE;
        end
        drcp_pkg::ST_MEM_WAIT: begin
          if (mem_wr_ack)
            state <= drcp_pkg::ST_SETTLE;
        end
        drcp_pkg::ST_SETTLE: begin
          state <= drcp_pkg::ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      reg_read_req     <= 1'b0;
      reg_write_strobe <= 1'b0;
      reg_group        <= '0;
      reg_sp_long      <= 1'b0;
      reg_write_data   <= '0;
    end else begin
      reg_read_req     <= cmd_read || (reg_read_req && !reg_read_valid);
      reg_write_strobe <= cmd_write;
      if (cmd_read || cmd_write) begin
        reg_group   <= cmd_group;
        reg_sp_long <= long_address_mode;
      end
      if (cmd_write)
        reg_write_data <= stage_val;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      read_result_upper <= '0;
      read_result_high  <= '0;
      read_result_low   <= '0;
    end else if (state == drcp_pkg::ST_READ_WAIT && reg_read_valid) begin
      read_result_upper <= reg_read_data[23:16];
      read_result_high  <= reg_read_data[15:8];
      read_result_low   <= reg_read_data[7:0];
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      mem_wr_req   <= 1'b0;
      mem_wr_addr  <= '0;
      mem_wr_data  <= '0;
      pc_increment <= 1'b0;
    end else begin
      mem_wr_req   <= hit_mem || (mem_wr_req && !mem_wr_ack);
      pc_increment <= state == drcp_pkg::ST_MEM_WAIT && mem_wr_ack;
      if (hit_mem) begin
        mem_wr_addr <= mem_addr;
        mem_wr_data <= q_data;
      end
    end
  end

endmodule : drcp_debug_register_command_port

// >>> drcp_pkg.sv
package drcp_pkg;

  // ----------------------------------------------------------------
  // Debug register addresses in the write-only space
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W     = 8;
  localparam logic [7:0] ADDR_WR_UPPER = 8'h13;
  localparam logic [7:0] ADDR_WR_HIGH  = 8'h14;
  localparam logic [7:0] ADDR_WR_LOW   = 8'h15;
  localparam logic [7:0] ADDR_COMMAND  = 8'h16;
  localparam logic [7:0] ADDR_MEM_WR   = 8'h30;

  // ----------------------------------------------------------------
  // Command byte layout
  // ----------------------------------------------------------------
  localparam int unsigned CMD_TAG_MSB   = 7;
  localparam int unsigned CMD_TAG_LSB   = 3;
  localparam int unsigned CMD_GROUP_MSB = 2;
  localparam logic [4:0] CMD_TAG_READ   = 5'h00;
  localparam logic [4:0] CMD_TAG_WRITE  = 5'h10;
  localparam logic [2:0] GROUP_SP       = 3'h6;
  localparam logic [2:0] GROUP_PC       = 3'h7;

  // ----------------------------------------------------------------
  // Widths and buffering
  // ----------------------------------------------------------------
  localparam int unsigned DATA_W     = 8;
  localparam int unsigned STAGE_W    = 24;
  localparam int unsigned GROUP_W    = 3;
  localparam int unsigned FIFO_DEPTH = 8;
  localparam logic [7:0]  ADDR_STEP  = 8'h01;

  typedef enum logic [3:0] {
    ST_IDLE      = 4'b0001,
    ST_READ_WAIT = 4'b0010,
    ST_MEM_WAIT  = 4'b0100,
    ST_SETTLE    = 4'b1000
  } drcp_state_t;

endpackage : drcp_pkg

// >>> drcp_cpu_model.sv
`timescale 1ns/1ps
// ----
// CPU register file and memory partner
// ----
module drcp_cpu_model (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // Register file
  input  wire logic        reg_read_req,
  input  wire logic        reg_write_strobe,
  input  wire logic [2:0]  reg_group,
  input  wire logic        reg_sp_long,
  input  wire logic [23:0] reg_write_data,
  output logic             reg_read_valid,
  output logic      [23:0] reg_read_data,
  // CPU state
  output logic      [7:0]  memory_base_page,
  output logic      [23:0] cpu_pc,
  input  wire logic        pc_increment,
  // Memory
  input  wire logic        mem_wr_req,
  output logic             mem_wr_ack
);
  logic [23:0] regs [8];
  logic [23:0] sp   [2];
  logic        slow;
  logic [23:0] rd;
  assign rd = (reg_group == 3'h6) ? sp[reg_sp_long] : regs[reg_group];
  // Outside a valid cycle the data shows the inverse, so a late sample cannot pass.
  assign reg_read_data = reg_read_valid ? rd : ~rd;
  assign memory_base_page = regs[0][23:16];
  assign cpu_pc = regs[7];
  // Answers alternate between one and two cycles of wait.
  always_ff @(posedge clk) begin
    slow <= reset ? 1'h0 : ~slow;
    reg_read_valid <= !reset && reg_read_req && !reg_read_valid && slow;
    mem_wr_ack <= !reset && mem_wr_req && !mem_wr_ack && !slow;
    if (reg_write_strobe && reg_group == 3'h6) sp[reg_sp_long] <= reg_write_data;
    else if (reg_write_strobe) regs[reg_group] <= reg_write_data;
    else if (pc_increment) regs[7] <= regs[7] + 24'h00_0001;
  end
endmodule : drcp_cpu_model

// >>> drcp_checker_props.sv
`timescale 1ns/1ps
// ----
// Port checker
// ----
module drcp_chk (
  // Clock and reset
  input wire logic        clk,
  input wire logic        reset,
  // Register file
  input wire logic        reg_read_req,
  input wire logic        reg_read_valid,
  input wire logic [23:0] reg_read_data,
  input wire logic        reg_write_strobe,
  input wire logic [2:0]  reg_group,
  input wire logic        reg_sp_long,
  input wire logic [7:0]  read_result_upper,
  input wire logic [7:0]  read_result_high,
  input wire logic [7:0]  read_result_low,
  // CPU state and memory
  input wire logic        long_address_mode,
  input wire logic [7:0]  memory_base_page,
  input wire logic [23:0] cpu_pc,
  input wire logic        pc_increment,
  input wire logic        mem_wr_req,
  input wire logic        mem_wr_ack,
  input wire logic [23:0] mem_wr_addr
);
  logic [23:0] short_addr;
  assign short_addr = {memory_base_page, cpu_pc[15:0]};
  default clocking @(posedge clk);
  endclocking
  default disable iff (reset);
  AST_WR_PULSE: assert property (reg_write_strobe |=> !reg_write_strobe)
    else $error("write strobe too wide");
  AST_RD_HOLD: assert property (
    reg_read_req && !reg_read_valid |=> reg_read_req && $stable(reg_group))
    else $error("read request dropped");
  AST_RD_LOAD: assert property (
    reg_read_req && reg_read_valid |=> !reg_read_req &&
    {read_result_upper, read_result_high, read_result_low} == $past(reg_read_data))
    else $error("read result wrong");
  AST_SP_SEL: assert property (
    $rose(reg_read_req) || reg_write_strobe |-> reg_sp_long == $past(long_address_mode))
    else $error("stack pointer select");
  AST_MEM_HOLD: assert property (
    mem_wr_req && !mem_wr_ack |=> mem_wr_req && $stable(mem_wr_addr))
    else $error("memory request moved");
  AST_MEM_ADDR: assert property ($rose(mem_wr_req) |-> mem_wr_addr ==
    ($past(long_address_mode) ? $past(cpu_pc) : $past(short_addr)))
    else $error("memory address wrong");
  AST_PC_STEP: assert property (mem_wr_req && mem_wr_ack |=> !mem_wr_req && pc_increment)
    else $error("no counter step");
  AST_PC_ONCE: assert property (pc_increment |=> !pc_increment && !mem_wr_req)
    else $error("counter step repeated");
endmodule : drcp_chk

bind drcp_debug_register_command_port drcp_chk i_drcp_chk (.*);

// >>> tb.sv
`timescale 1ns/1ps
// ----
// Testbench
// ----
module tb;
  logic        clk, reset, dbg_addr_load, dbg_data_valid, dbg_data_ready, long_address_mode;
  logic        reg_read_req, reg_write_strobe, reg_sp_long, reg_read_valid, pc_increment;
  logic        mem_wr_req, mem_wr_ack;
  logic        rv_d = 1'h0;
  logic [2:0]  reg_group;
  logic [7:0]  dbg_addr, dbg_data, read_result_upper, read_result_high, read_result_low;
  logic [7:0]  memory_base_page, mem_wr_data;
  logic [15:0] junk [4] = '{16'h1608, 16'h1609, 16'h1688, 16'h2087};
  logic [23:0] reg_write_data, reg_read_data, cpu_pc, mem_wr_addr, v;
  logic [23:0] val [8];
  logic [23:0] sp  [2];
  logic [35:0] exp_q [$];
  integer      seed, mismatches, tests_run;
  integer      cycles = 0;

  drcp_debug_register_command_port i_drcp_debug_register_command_port (.*);
  drcp_cpu_model i_drcp_cpu_model (.*);

  initial begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end

  task automatic complete_run;
    if (exp_q.size() != 0) mismatches++;
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : complete_run

  task automatic check(input logic [35:0] obs);
    logic [35:0] e;
    tests_run++;
    e = (exp_q.size() != 0) ? exp_q.pop_front() : ~obs;
    if (e !== obs) begin
      mismatches++;
      $display("mismatch at %0t: saw %h expected %h", $time, obs, e);
    end
  endtask : check

  // Results are serial through one executor, so one queue keeps their order.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    rv_d <= reg_read_valid && reg_read_req;
    if (rv_d) check({12'h100, read_result_upper, read_result_high, read_result_low});
    if (reg_write_strobe) check({4'h2, 4'h0, reg_sp_long, reg_group, reg_write_data});
    if (mem_wr_req && mem_wr_ack) check({4'h3, mem_wr_data, mem_wr_addr});
    if (cycles == 5000) begin
      mismatches++;
      complete_run;
    end
  end

  task automatic send(input logic ld, input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    dbg_addr_load = ld;
    dbg_addr = a;
    dbg_data = d;
    dbg_data_valid = 1'h1;
    do @(posedge clk); while (dbg_data_ready !== 1'h1);
  endtask : send

  task automatic idle(input integer n);
    @(negedge clk);
    dbg_data_valid = 1'h0;
    dbg_addr_load = 1'h0;
    repeat (n) @(posedge clk);
  endtask : idle

  task automatic wr(input logic [2:0] g, input logic [23:0] d);
    exp_q.push_back({4'h2, 4'h0, long_address_mode, g, d});
    if (g == 3'h6) sp[long_address_mode] = d;
    else val[g] = d;
    send(1'h1, 8'h13, d[23:16]);
    send(1'h0, 8'($random(seed)), d[15:8]);
    send(1'h0, 8'($random(seed)), d[7:0]);
    send(1'h0, 8'($random(seed)), {5'h10, g});
    idle(6);
  endtask : wr

  task automatic rd(input logic [2:0] g);
    exp_q.push_back({12'h100, (g == 3'h6) ? sp[long_address_mode] : val[g]});
    send(1'h1, 8'h16, {5'h00, g});
    idle(6);
  endtask : rd

  initial begin
    seed = 37733;
    mismatches = 0;
    tests_run = 0;
    reset = 1'h1;
    long_address_mode = 1'h0;
    dbg_addr_load = 1'h0;
    dbg_data_valid = 1'h0;
    dbg_addr = 8'h00;
    dbg_data = 8'h00;
    repeat (10) @(posedge clk);
    @(negedge clk);
    reset = 1'h0;
    for (int m = 0; m < 2; m++) begin
      @(negedge clk);
      long_address_mode = m[0];
      for (int g = 0; g < 8; g++) wr(g[2:0], 24'($random(seed)));
      // Unused codes and an unmapped address must leave no trace at all.
      foreach (junk[i]) send(1'h1, junk[i][15:8], junk[i][7:0]);
      idle(8);
      for (int g = 0; g < 8; g++) rd(g[2:0]);
      $display("test registers %0d done", m);
      wr(3'h7, 24'h12_FFFE);
      for (int i = 0; i < 5; i++) begin
        v = 24'($random(seed));
        exp_q.push_back({4'h3, v[7:0], (m != 0) ? val[7] : {val[0][23:16], val[7][15:0]}});
        val[7] = val[7] + 24'h00_0001;
        send(i == 0, (i == 0) ? 8'h30 : v[15:8], v[7:0]);
      end
      idle(30);
      rd(3'h7);
      $display("test memory %0d done", m);
    end
    idle(20);
    complete_run;
  end
endmodule : tb
